// *** design/pwr_seq_cfg.svh ***
// Purpose: timing and counter width constants for the power state sequencer
// Assumes: 200 MHz clock, 5 ns period
// Notes: long counts are also top-level parameters so a bench can shorten
`ifndef PWR_SEQ_CFG_SVH
`define PWR_SEQ_CFG_SVH
`define CLK_PERIOD_NS 5
`define BTN_MIN_MS 50
`define BTN_OVR_MS 4000
`define NS_PER_MS 1000000
// whole cycles per millisecond; exact at a 5 ns period
`define CYC_PER_MS (`NS_PER_MS / `CLK_PERIOD_NS)
// product taken in cycles so the 4 s count fits a 32-bit int
`define BTN_MIN_CYC (`BTN_MIN_MS * `CYC_PER_MS)
`define BTN_OVR_CYC (`BTN_OVR_MS * `CYC_PER_MS)
`define CNT_W 30
`endif

// *** design/pwr_seq_pkg.sv ***
// Purpose: types shared by the power state sequencer
// Assumes: nothing
// Notes: state codes are visible on the power_state output
`default_nettype none
package pwr_seq_pkg;
    typedef enum logic [2:0] {
        ST_MECH_OFF = 3'b000,
        ST_SOFT_OFF = 3'b001,
        ST_RAMP = 3'b010,
        ST_WAIT_GOOD = 3'b011,
        ST_RUN = 3'b100
    } pstate_t;
endpackage : pwr_seq_pkg
`default_nettype wire

// *** design/sync2.sv ***
// Purpose: two flip-flop level synchroniser
// Assumes: single clock, synchronous reset
// Notes: first stage is read only by the second stage
`default_nettype none
module sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk, // clock
    input wire logic rst, // sync reset, active high
    input wire logic d, // async input
    output logic q // synchronised level
);
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end
    assign q = sync_q;
endmodule : sync2
`default_nettype wire

// *** design/module_power_state_sequencer.sv ***
// Purpose: sequence a compute module through mech-off, soft-off and run
// Assumes: logic powered from standby (dual) or main (single) domain
// Notes: rail presence inputs are already clean levels from comparators
// Overview of operation
// - dual mode: standby rail up enters soft-off, then heads for running.
// - dual mode: assert active-low supply-on to switch main rail on.
// - after enabling main rail, wait for power-good high before running.
// - mech-off without standby ignores button, power-good and supply-on.
// - single mode starts on main input alone; open power-good reads high.
// - single mode leaves soft-off on button event or main reapply.
// - single mode offers no sleep states, only off, soft-off, running.
// - button held low four seconds or more removes module power.
// - power-good fall in running goes to soft-off; low blocks running.
`include "pwr_seq_cfg.svh"
`default_nettype none
module module_power_state_sequencer
    import pwr_seq_pkg::*;
#(
    parameter int BTN_MIN_CYCLES = `BTN_MIN_CYC,
    parameter int BTN_OVR_CYCLES = `BTN_OVR_CYC
) (
    input wire logic clk, // 200 MHz clock
    input wire logic rst, // sync reset, active high
    input wire logic single_mode, // 1: single-supply, 0: dual (atx)
    input wire logic standby_rail, // standby rail present
    input wire logic main_rail, // main input rail present
    input wire logic power_button_n, // power button, active low
    input wire logic supply_good_in, // power good, open reads high
    output logic supply_on_n, // supply on request, active low
    output logic sleep_state_out_n, // low in mech-off and soft-off
    output logic module_power_en, // enables module rails (running)
    output pstate_t power_state // current sequencer state
);
    if (BTN_MIN_CYCLES < 1 || BTN_OVR_CYCLES <= BTN_MIN_CYCLES ||
        BTN_OVR_CYCLES >= (1 << `CNT_W)) begin : g_bad_timing
        $error("bad button timing parameters");
    end

    logic btn_n_s;
    logic good_s;
    // pull-up modelled by bench; reset to high so open input reads high
    sync2 #(.RESET_VAL(1'b1)) u_btn_sync (
        .clk(clk), .rst(rst), .d(power_button_n), .q(btn_n_s));
    sync2 #(.RESET_VAL(1'b1)) u_good_sync (
        .clk(clk), .rst(rst), .d(supply_good_in), .q(good_s));

    // logic lives on the rail that feeds it
    logic rail_up;
    assign rail_up = single_mode ? main_rail : standby_rail;

    pstate_t state_q, state_d;
    logic [`CNT_W-1:0] press_q, press_d;
    logic good_q, good_d;
    logic main_q, main_d;
    logic ovr_done_q, ovr_done_d;
    logic boot_q, boot_d;
    logic btn_event;
    logic btn_ovr;
    logic good_fall;
    logic main_reapply;

    // event fires on release after a press of valid length
    assign btn_event = btn_n_s && !ovr_done_q &&
        (press_q >= `CNT_W'(BTN_MIN_CYCLES)) &&
        (press_q < `CNT_W'(BTN_OVR_CYCLES));
    assign btn_ovr = !btn_n_s && !ovr_done_q &&
        (press_q == `CNT_W'(BTN_OVR_CYCLES - 1));
    assign good_fall = good_q && !good_s;
    assign main_reapply = main_rail && !main_q;

    always_comb begin
        press_d = press_q;
        ovr_done_d = ovr_done_q;
        if (btn_n_s) begin
            press_d = '0;
            ovr_done_d = 1'b0;
        end else if (press_q != `CNT_W'(BTN_OVR_CYCLES)) begin
            press_d = press_q + `CNT_W'(1);
        end
        if (btn_ovr) begin
            ovr_done_d = 1'b1;
        end
        good_d = good_s;
        main_d = main_rail;
        // only the entry from mech-off runs on by itself; after a fail
        // or an override, soft-off waits for a button event
        boot_d = !single_mode && (state_q == ST_MECH_OFF);
    end

    always_comb begin
        state_d = state_q;
        if (!rail_up) begin
            state_d = ST_MECH_OFF;
        end else begin
            case (state_q)
                ST_MECH_OFF: begin
                    // dual: soft-off then on; single: to wait-good
                    state_d = single_mode ? ST_WAIT_GOOD
                        : ST_SOFT_OFF;
                end
                ST_SOFT_OFF: begin
                    if (single_mode) begin
                        if (btn_event || main_reapply) begin
                            state_d = ST_WAIT_GOOD;
                        end
                    end else if (btn_event || boot_q) begin
                        // first entry after standby ramp proceeds at once
                        state_d = ST_RAMP;
                    end
                end
                ST_RAMP: begin
                    state_d = ST_WAIT_GOOD;
                end
                ST_WAIT_GOOD: begin
                    if (good_s) begin
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (good_fall) begin
                        state_d = ST_SOFT_OFF;
                    end
                end
                default: state_d = ST_MECH_OFF;
            endcase
            if (btn_ovr && state_q != ST_MECH_OFF) begin
                state_d = ST_SOFT_OFF;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_MECH_OFF;
            press_q <= '0;
            ovr_done_q <= 1'b0;
            good_q <= 1'b1;
            main_q <= 1'b1;
            boot_q <= 1'b0;
        end else begin
            state_q <= state_d;
            press_q <= press_d;
            ovr_done_q <= ovr_done_d;
            good_q <= good_d;
            main_q <= main_d;
            boot_q <= boot_d;
        end
    end

    // outputs registered from next state; no sleep states exist
    logic on_d;
    assign on_d = (state_d == ST_RAMP) || (state_d == ST_WAIT_GOOD) ||
        (state_d == ST_RUN);
    always_ff @(posedge clk) begin
        if (rst) begin
            supply_on_n <= 1'b1;
            sleep_state_out_n <= 1'b0;
            module_power_en <= 1'b0;
            power_state <= ST_MECH_OFF;
        end else begin
            supply_on_n <= !on_d;
            sleep_state_out_n <= on_d;
            module_power_en <= (state_d == ST_RUN);
            power_state <= state_d;
        end
    end

    // assertions
    default clocking chk_cb @(posedge clk);
    endclocking
    default disable iff (rst);
    run_needs_good_a: assert property (
        (state_q != ST_RUN) && (state_d == ST_RUN) |-> good_s)
        else $error("running entered while power good low");
    good_fall_off_a: assert property (
        (state_q == ST_RUN) && good_fall && rail_up
        |=> state_q == ST_SOFT_OFF)
        else $error("power good fall did not reach soft-off");
    supply_on_ramp_a: assert property (
        state_q == ST_RAMP |-> !supply_on_n)
        else $error("supply on not asserted in ramp");
    wait_good_a: assert property (
        (state_q == ST_WAIT_GOOD) && !good_s && !btn_ovr && rail_up
        |=> state_q == ST_WAIT_GOOD)
        else $error("left wait before power good");
    mech_off_a: assert property (
        !rail_up |=> (state_q == ST_MECH_OFF) && supply_on_n)
        else $error("not mech-off without rail");
    standby_start_a: assert property (
        (state_q == ST_MECH_OFF) && !single_mode && standby_rail
        |=> state_q == ST_SOFT_OFF)
        else $error("no soft-off after standby up");
    single_start_a: assert property (
        (state_q == ST_MECH_OFF) && single_mode && main_rail
        |=> state_q == ST_WAIT_GOOD)
        else $error("single mode did not start");
    button_override_a: assert property (
        btn_ovr && rail_up && state_q != ST_MECH_OFF
        |=> state_q == ST_SOFT_OFF ##1 !module_power_en)
        else $error("override did not drop power");
    single_soft_off_a: assert property (
        single_mode && state_q == ST_SOFT_OFF && main_rail
        && !btn_event && main_q |=> state_q == ST_SOFT_OFF)
        else $error("single soft-off left without cause");
    soft_off_hold_a: assert property (
        !single_mode && (state_q == ST_SOFT_OFF) && !boot_q && !btn_event
        && rail_up |=> state_q == ST_SOFT_OFF)
        else $error("dual soft-off left without button event");
    no_sleep_a: assert property (
        single_mode |-> state_q != ST_RAMP)
        else $error("single mode used the supply ramp state");
    sync_path_a: assert property (
        $fell(good_s) |-> $past(supply_good_in, 2) == 1'b0)
        else $error("power good used unsynchronised");
    run_c: cover property (state_q == ST_WAIT_GOOD ##1 state_q == ST_RUN);
    fail_c: cover property (state_q == ST_RUN ##1 state_q == ST_SOFT_OFF);
    event_c: cover property (btn_event && state_q == ST_SOFT_OFF);
    ovr_c: cover property (btn_ovr);
    restart_c: cover property (btn_event && !single_mode && !boot_q);
endmodule : module_power_state_sequencer
`default_nettype wire

// *** tb/psu_model.sv ***
// Purpose: carrier supply model, main rail and power good
// Assumes: sequencer clock, dual mode main rail follows supply_on_n
// Notes: open power good pulled high; in dual mode good lags the rail by ten cycles, in single mode it follows fail only
`default_nettype none
module psu_model (
    input wire logic clk, // clock
    input wire logic single_mode, // supply mode
    input wire logic vcc_in, // main input in single mode
    input wire logic supply_on_n, // on request, active low
    input wire logic fail, // pulls power good low
    output logic main_rail, // main rail present
    output logic supply_good_in // power good
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ramp_q = 4'h0;
    always @(posedge clk) begin
        if (supply_on_n) ramp_q <= 4'h0;
        else if (ramp_q != 4'hf) ramp_q <= ramp_q + 4'h1;
    end
    assign main_rail = single_mode ? vcc_in : ~supply_on_n;
    // slow good exposes a sequencer that skips the wait
    assign supply_good_in = single_mode ? ~fail
                          : (ramp_q > 4'h9) & ~fail;
endmodule : psu_model
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: self-checking bench for the power state sequencer
// Assumes: shortened button counts 4 and 20
// Notes: inputs change 1 ns after the rising edge
`default_nettype none
module tb import pwr_seq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, single_mode = 1'b0, standby_rail = 1'b0;
    logic vcc_in = 1'b0, power_button_n = 1'b1, fail = 1'b0;
    logic main_rail, supply_good_in, supply_on_n, sleep_n, pwr_en;
    pstate_t power_state;
    int mismatches = 0, checks_done = 0;
    always #2.5 clk = ~clk;
    psu_model psu (.clk(clk), .single_mode(single_mode), .vcc_in(vcc_in),
        .supply_on_n(supply_on_n), .fail(fail), .main_rail(main_rail),
        .supply_good_in(supply_good_in));
    module_power_state_sequencer #(.BTN_MIN_CYCLES(4), .BTN_OVR_CYCLES(20))
    dut (.clk(clk), .rst(rst), .single_mode(single_mode),
        .standby_rail(standby_rail), .main_rail(main_rail),
        .power_button_n(power_button_n), .supply_good_in(supply_good_in),
        .supply_on_n(supply_on_n), .sleep_state_out_n(sleep_n),
        .module_power_en(pwr_en), .power_state(power_state));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic chk_state(input string nm, input pstate_t e);
        checks_done++;
        if (power_state !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, power_state);
        end
    endtask : chk_state
    task automatic wait_state(input pstate_t s, input int max);
        for (int i = 0; i < max && power_state !== s; i++) step(1);
        chk_state("state", s);
    endtask : wait_state
    task automatic press(input int n);
        power_button_n = 1'b0;
        step(n);
        power_button_n = 1'b1;
        step(1);
    endtask : press
    task automatic do_reset(input logic single);
        rst = 1'b1;
        single_mode = single;
        step(12);
        rst = 1'b0;
    endtask : do_reset
    task automatic t_mech_off();
        for (int i = 0; i < 4; i++) begin
            power_button_n = i[0];
            fail = i[1];
            step(3);
            chk_state("mech-off", ST_MECH_OFF);
            chk_bit("supply_on_n", 1'b1, supply_on_n);
        end
        power_button_n = 1'b1;
        fail = 1'b0;
        $display("test mech_off done");
    endtask : t_mech_off
    task automatic t_dual_up();
        standby_rail = 1'b1;
        wait_state(ST_SOFT_OFF, 3);
        wait_state(ST_RAMP, 2);
        chk_bit("supply_on_n", 1'b0, supply_on_n);
        chk_bit("sleep_n", 1'b1, sleep_n);
        wait_state(ST_WAIT_GOOD, 2);
        chk_bit("pwr_en", 1'b0, pwr_en);
        wait_state(ST_RUN, 20);
        chk_bit("pwr_en", 1'b1, pwr_en);
        $display("test dual_up done");
    endtask : t_dual_up
    task automatic t_power_fail();
        fail = 1'b1;
        wait_state(ST_SOFT_OFF, 4);
        chk_bit("supply_on_n", 1'b1, supply_on_n);
        press(6);
        wait_state(ST_WAIT_GOOD, 6);
        step(30);
        chk_bit("not running", 1'b1, power_state !== ST_RUN);
        chk_bit("pwr_en", 1'b0, pwr_en);
        fail = 1'b0;
        wait_state(ST_RUN, 10);
        $display("test power_fail done");
    endtask : t_power_fail
    task automatic t_override();
        power_button_n = 1'b0;
        step(18);
        chk_state("still running", ST_RUN);
        wait_state(ST_SOFT_OFF, 8);
        chk_bit("pwr_en", 1'b0, pwr_en);
        step(10);
        power_button_n = 1'b1;
        step(10);
        chk_state("stays off", ST_SOFT_OFF);
        press(6);
        wait_state(ST_RUN, 30);
        $display("test override done");
    endtask : t_override
    task automatic t_single();
        do_reset(1'b1);
        standby_rail = 1'b0;
        vcc_in = 1'b1;
        wait_state(ST_RUN, 20);
        press(25);
        chk_state("override", ST_SOFT_OFF);
        press(2);
        step(10);
        chk_state("short press", ST_SOFT_OFF);
        press(6);
        wait_state(ST_RUN, 20);
        press(25);
        vcc_in = 1'b0;
        wait_state(ST_MECH_OFF, 4);
        vcc_in = 1'b1;
        wait_state(ST_RUN, 20);
        $display("test single done");
    endtask : t_single
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
    initial begin
        do_reset(1'b0);
        t_mech_off();
        t_dual_up();
        t_power_fail();
        t_override();
        t_single();
        finish_test();
    end
endmodule : tb
`default_nettype wire
